// ---- rtl/hfcb_ctrl.v ----
// continuous bus mode command handler: commands, head polling, ring FIFO of tag records
`timescale 1ns/1ps
`include "hfcb_regs.vh"
module hfcb_ctrl #(
	parameter BYPASS_CYC   = `HFCB_BYPASS_MS * `HFCB_CLK_KHZ,
	parameter WAIT_INV_CYC = `HFCB_WAIT_INV_MS * `HFCB_CLK_KHZ,
	parameter WAIT_RD_CYC  = `HFCB_WAIT_RD_MS * `HFCB_CLK_KHZ,
	parameter WAIT_WR_CYC  = `HFCB_WAIT_WR_MS * `HFCB_CLK_KHZ
) (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        ce,
	input  wire        cmd_strobe,
	input  wire [15:0] cmd_code,
	input  wire [2:0]  tag_type,
	input  wire [2:0]  continuous_cmd_select,
	input  wire [7:0]  continuous_length,
	input  wire [15:0] continuous_start_addr,
	input  wire        grouping_en,
	input  wire [15:0] buf_read_len,
	output wire        cmd_busy,
	output wire [15:0] resp_code,
	output wire        resp_error,
	output wire [15:0] fifo_bytes_waiting,
	output wire        fifo_full_err,
	output wire        cont_running,
	output wire [7:0]  buf_byte,
	output wire        buf_byte_valid,
	output wire        head_preload,
	output wire [7:0]  head_preload_mask,
	output wire [2:0]  preload_op,
	output wire [2:0]  preload_tag,
	output wire [7:0]  preload_len,
	output wire [15:0] preload_addr,
	output wire        head_poll,
	output wire [7:0]  head_poll_addr,
	input  wire        head_rec_valid,
	output wire        head_rec_ready,
	input  wire [63:0] head_rec_uid,
	input  wire [7:0]  head_rec_addr,
	input  wire        head_attach,
	input  wire [7:0]  head_attach_addr,
	input  wire        head_detach,
	input  wire [7:0]  head_detach_addr,
	output wire        addr_assign_valid,
	output wire [7:0]  addr_assign
);
	localparam [2:0]  ST_WAIT = 3'b001;
	localparam [2:0]  ST_SCAN = 3'b010;
	localparam [2:0]  ST_READ = 3'b100;
	localparam [21:0] BYP_C   = BYPASS_CYC[21:0];
	localparam [21:0] WINV_C  = WAIT_INV_CYC[21:0];
	localparam [21:0] WRD_C   = WAIT_RD_CYC[21:0];
	localparam [21:0] WWR_C   = WAIT_WR_CYC[21:0];

	reg [87:0] ring_mem [0:`HFCB_RING_DEPTH-1];
	reg [2:0]  state_reg;
	reg        running_reg;
	reg        group_reg;
	reg [2:0]  op_reg;
	reg [10:0] wr_ptr_reg;
	reg [10:0] rd_ptr_reg;
	reg [11:0] rec_count_reg;
	reg [10:0] scan_idx_reg;
	reg [11:0] scan_left_reg;
	reg [71:0] hold_rec_reg;
	reg [15:0] byte_left_reg;
	reg [3:0]  byte_idx_reg;
	reg        full_err_reg;
	reg [15:0] resp_code_reg;
	reg        resp_err_reg;
	reg [15:0] bytes_wait_reg;
	reg [7:0]  buf_byte_reg;
	reg        buf_valid_reg;
	reg        preload_reg;
	reg [7:0]  preload_mask_reg;
	reg [2:0]  pl_op_reg;
	reg [2:0]  pl_tag_reg;
	reg [7:0]  pl_len_reg;
	reg [15:0] pl_addr_reg;
	reg        poll_reg;
	reg [2:0]  poll_idx_reg;
	reg [7:0]  poll_addr_reg;
	reg [7:0]  active_mask_reg;
	reg        assign_valid_reg;
	reg [7:0]  assign_addr_reg;

	wire        rf_valid;
	wire [71:0] rf_data;
	wire        rf_ready;
	wire        pass_start;
	wire        st_wait = state_reg[0];
	wire        st_scan = state_reg[1];
	wire        st_read = state_reg[2];
	wire [3:0]  rec_bytes = group_reg ? `HFCB_REC_BYTES_GROUP : `HFCB_REC_BYTES_PLAIN;
	wire        ring_full = rec_count_reg == (group_reg ? `HFCB_MAX_RECS_GROUP : `HFCB_MAX_RECS_PLAIN);
	wire [87:0] scan_word = ring_mem[scan_idx_reg];
	wire [87:0] rd_word   = ring_mem[rd_ptr_reg];
	wire        scan_hit  = scan_word[87:24] == hold_rec_reg[71:8];
	wire [15:0] cnt_inc   = (scan_word[15:0] == 16'hFFFF) ? 16'hFFFF : scan_word[15:0] + 16'h0001;
	wire [15:0] rc16      = {4'h0, rec_count_reg};
	wire [15:0] bytes_now = group_reg ? ((rc16 << 3) + (rc16 << 2)) : ((rc16 << 3) + (rc16 << 1));

	// records are taken only while no command is pending, so a command never waits on the head bus
	wire        take_rec  = st_wait & ~cmd_strobe & rf_valid;
	wire        app_we    = (take_rec & running_reg & ~(group_reg & rec_count_reg != 12'h000) & ~ring_full) |
	                        (st_scan & scan_left_reg == 12'h000 & ~ring_full);
	wire        upd_we    = st_scan & scan_left_reg != 12'h000 & scan_hit;
	wire        drop_full = ((take_rec & running_reg & ~(group_reg & rec_count_reg != 12'h000)) |
	                        (st_scan & scan_left_reg == 12'h000)) & ring_full;
	wire [71:0] app_rec   = st_wait ? rf_data : hold_rec_reg;
	wire        rd_more   = byte_idx_reg != 4'h0 ||
	                        (rec_count_reg != 12'h000 && byte_left_reg >= {12'h000, rec_bytes});
	wire        rd_last   = byte_idx_reg == rec_bytes - 4'h1;
	assign rf_ready = take_rec;

	// block size mask by tag type
	reg  [7:0]  blk_mask;
	reg         tag_ok;
	always @* begin
		blk_mask = 8'h00;
		tag_ok   = 1'b1;
		case (tag_type)
			`HFCB_TAG_BLK4:  blk_mask = 8'h03;
			`HFCB_TAG_BLK8:  blk_mask = 8'h07;
			`HFCB_TAG_BLK32: blk_mask = 8'h1F;
			default:         tag_ok = 1'b0;
		endcase
	end
	wire rw_op   = continuous_cmd_select == `HFCB_OP_READ || continuous_cmd_select == `HFCB_OP_WRITE;
	wire sel_ok  = continuous_cmd_select <= `HFCB_OP_WRITE;
	wire rw_ok   = tag_ok &&
	               continuous_length != 8'h00 && continuous_length <= `HFCB_MAX_USER_BYTES &&
	               (continuous_length & blk_mask) == 8'h00 &&
	               (continuous_start_addr[7:0] & blk_mask) == 8'h00;
	wire cont_ok = sel_ok && (!rw_op || rw_ok);

	reg [21:0] wait_sel;
	always @* begin
		case (op_reg)
			`HFCB_OP_INVENTORY: wait_sel = WINV_C;
			`HFCB_OP_WRITE:     wait_sel = WWR_C;
			default:            wait_sel = WRD_C;
		endcase
	end

	// lowest free address and next active head after the current poll index
	wire [15:0] rot_mask = ({active_mask_reg, active_mask_reg} >> ({1'b0, poll_idx_reg} + 4'h1));
	wire [8:0] free_seen;
	wire [8:0] act_seen;
	wire [2:0] free_term [0:8];
	wire [2:0] act_term  [0:8];
	assign free_seen[0] = 1'b0;
	assign act_seen[0]  = 1'b0;
	assign free_term[0] = 3'h0;
	assign act_term[0]  = 3'h0;
	genvar gi;
	generate
		for (gi = 0; gi < `HFCB_HEADS; gi = gi + 1) begin : g_pick
			localparam [2:0] IDX = gi;
			assign free_seen[gi+1] = free_seen[gi] | ~active_mask_reg[gi];
			assign act_seen[gi+1]  = act_seen[gi] | rot_mask[gi];
			assign free_term[gi+1] = free_term[gi] | ((~active_mask_reg[gi] & ~free_seen[gi]) ? IDX : 3'h0);
			assign act_term[gi+1]  = act_term[gi] | ((rot_mask[gi] & ~act_seen[gi]) ? IDX : 3'h0);
		end
	endgenerate
	wire [2:0] next_poll = poll_idx_reg + 3'h1 + act_term[8];

	hfcb_fifo #(
		.WIDTH (72),
		.DEPTH (4),
		.AW    (2)
	) u_rec_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.ce        (ce),
		.in_valid  (head_rec_valid),
		.in_ready  (head_rec_ready),
		.in_data   ({head_rec_uid, head_rec_addr}),
		.out_valid (rf_valid),
		.out_ready (rf_ready),
		.out_data  (rf_data)
	);

	hfcb_slot_timer u_timer (
		.clk        (clk),
		.arst_n     (arst_n),
		.ce         (ce),
		.run        (running_reg & (|active_mask_reg)),
		.bypass_cyc (BYP_C),
		.wait_cyc   (wait_sel),
		.pass_start (pass_start),
		.in_bypass  ()
	);

	// ring store holds data only, so it carries no reset
	always @(posedge clk) begin
		if (ce && app_we) begin
			ring_mem[wr_ptr_reg] <= {app_rec, 16'h0001};
		end else if (ce && upd_we) begin
			ring_mem[scan_idx_reg] <= {scan_word[87:24], hold_rec_reg[7:0], cnt_inc};
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg        <= ST_WAIT;
			running_reg      <= 1'b0;
			group_reg        <= 1'b0;
			op_reg           <= `HFCB_OP_INVENTORY;
			wr_ptr_reg       <= 11'h000;
			rd_ptr_reg       <= 11'h000;
			rec_count_reg    <= 12'h000;
			scan_idx_reg     <= 11'h000;
			scan_left_reg    <= 12'h000;
			hold_rec_reg     <= 72'h0;
			byte_left_reg    <= 16'h0000;
			byte_idx_reg     <= 4'h0;
			full_err_reg     <= 1'b0;
			resp_code_reg    <= 16'h0000;
			resp_err_reg     <= 1'b0;
			bytes_wait_reg   <= 16'h0000;
			buf_byte_reg     <= 8'h00;
			buf_valid_reg    <= 1'b0;
			preload_reg      <= 1'b0;
			preload_mask_reg <= 8'h00;
			pl_op_reg        <= 3'h0;
			pl_tag_reg       <= 3'h0;
			pl_len_reg       <= 8'h00;
			pl_addr_reg      <= 16'h0000;
			poll_reg         <= 1'b0;
			poll_idx_reg     <= 3'h7;
			poll_addr_reg    <= 8'h00;
			active_mask_reg  <= 8'h00;
			assign_valid_reg <= 1'b0;
			assign_addr_reg  <= 8'h00;
		end else if (ce) begin
			preload_reg      <= 1'b0;
			poll_reg         <= 1'b0;
			buf_valid_reg    <= 1'b0;
			assign_valid_reg <= 1'b0;
			bytes_wait_reg   <= bytes_now;
			if (app_we) begin
				wr_ptr_reg    <= wr_ptr_reg + 11'h001;
				rec_count_reg <= rec_count_reg + 12'h001;
			end
			if (drop_full) begin
				full_err_reg <= 1'b1;
			end
			case (state_reg)
				ST_WAIT: begin
					if (cmd_strobe) begin
						resp_code_reg <= cmd_code;
						resp_err_reg  <= 1'b0;
						case (cmd_code)
							`HFCB_CMD_IDLE: begin
								resp_err_reg <= 1'b0;
							end
							`HFCB_CMD_CONT: begin
								if (cont_ok) begin
									running_reg      <= 1'b1;
									group_reg        <= grouping_en;
									op_reg           <= continuous_cmd_select;
									preload_reg      <= 1'b1;
									preload_mask_reg <= active_mask_reg;
									pl_op_reg        <= continuous_cmd_select;
									pl_tag_reg       <= tag_type;
									pl_len_reg       <= continuous_length;
									pl_addr_reg      <= continuous_start_addr;
								end else begin
									resp_err_reg <= 1'b1;
								end
							end
							`HFCB_CMD_READ_BUF: begin
								// the echo is given when the transfer ends
								resp_code_reg <= `HFCB_CMD_IDLE;
								byte_left_reg <= buf_read_len;
								byte_idx_reg  <= 4'h0;
								state_reg     <= ST_READ;
							end
							`HFCB_CMD_STOP: begin
								running_reg <= 1'b0;
							end
							`HFCB_CMD_RESET: begin
								running_reg   <= 1'b0;
								wr_ptr_reg    <= 11'h000;
								rd_ptr_reg    <= 11'h000;
								rec_count_reg <= 12'h000;
								full_err_reg  <= 1'b0;
							end
							default: begin
								resp_err_reg <= 1'b1;
							end
						endcase
					end else if (take_rec && running_reg && group_reg && rec_count_reg != 12'h000) begin
						hold_rec_reg  <= rf_data;
						scan_idx_reg  <= rd_ptr_reg;
						scan_left_reg <= rec_count_reg;
						state_reg     <= ST_SCAN;
					end
				end
				ST_SCAN: begin
					// linear search; heads answer once per pass, far slower than a full scan
					if (scan_left_reg == 12'h000 || scan_hit) begin
						state_reg <= ST_WAIT;
					end else begin
						scan_idx_reg  <= scan_idx_reg + 11'h001;
						scan_left_reg <= scan_left_reg - 12'h001;
					end
				end
				ST_READ: begin
					if (rd_more) begin
						buf_valid_reg <= 1'b1;
						buf_byte_reg  <= (byte_idx_reg == 4'h8) ? 8'h00 :
						                 (byte_idx_reg == 4'h9) ? rd_word[23:16] :
						                 (byte_idx_reg == 4'hA) ? rd_word[7:0] :
						                 (byte_idx_reg == 4'hB) ? rd_word[15:8] :
						                 rd_word[24 + 8 * byte_idx_reg +: 8];
						byte_left_reg <= byte_left_reg - 16'h0001;
						byte_idx_reg  <= rd_last ? 4'h0 : byte_idx_reg + 4'h1;
						if (rd_last) begin
							rd_ptr_reg    <= rd_ptr_reg + 11'h001;
							rec_count_reg <= rec_count_reg - 12'h001;
							if (!drop_full) begin
								full_err_reg <= 1'b0;
							end
						end
					end else begin
						resp_code_reg <= `HFCB_CMD_READ_BUF;
						resp_err_reg  <= 1'b0;
						state_reg     <= ST_WAIT;
					end
				end
				default: begin
					state_reg <= ST_WAIT;
				end
			endcase
			if (pass_start && running_reg && (|active_mask_reg)) begin
				poll_reg      <= 1'b1;
				poll_idx_reg  <= next_poll;
				poll_addr_reg <= {5'h00, next_poll} + 8'h01;
			end
			if (head_attach && head_attach_addr == `HFCB_HEAD_DEFAULT && !(&active_mask_reg)) begin
				active_mask_reg[free_term[8]] <= 1'b1;
				assign_valid_reg              <= 1'b1;
				assign_addr_reg               <= {5'h00, free_term[8]} + 8'h01;
			end else if (head_detach && head_detach_addr != 8'h00 && head_detach_addr <= `HFCB_HEADS) begin
				active_mask_reg[head_detach_addr[2:0] - 3'h1] <= 1'b0;
			end
		end
	end

	assign cmd_busy           = ~state_reg[0];
	assign resp_code          = resp_code_reg;
	assign resp_error         = resp_err_reg;
	assign fifo_bytes_waiting = bytes_wait_reg;
	assign fifo_full_err      = full_err_reg;
	assign cont_running       = running_reg;
	assign buf_byte           = buf_byte_reg;
	assign buf_byte_valid     = buf_valid_reg;
	assign head_preload       = preload_reg;
	assign head_preload_mask  = preload_mask_reg;
	assign preload_op         = pl_op_reg;
	assign preload_tag        = pl_tag_reg;
	assign preload_len        = pl_len_reg;
	assign preload_addr       = pl_addr_reg;
	assign head_poll          = poll_reg;
	assign head_poll_addr     = poll_addr_reg;
	assign addr_assign_valid  = assign_valid_reg;
	assign addr_assign        = assign_addr_reg;
endmodule

// ---- pkg/hfcb_regs.vh ----
// constants for the continuous bus mode command handler
`ifndef HFCB_REGS_VH
`define HFCB_REGS_VH

`define HFCB_CMD_IDLE        16'h0000
`define HFCB_CMD_CONT        16'h0010
`define HFCB_CMD_READ_BUF    16'h0011
`define HFCB_CMD_STOP        16'h0012
`define HFCB_CMD_RESET       16'h0800

`define HFCB_OP_INVENTORY    3'h0
`define HFCB_OP_READ         3'h1
`define HFCB_OP_TAG_INFO     3'h2
`define HFCB_OP_WRITE        3'h3

`define HFCB_TAG_AUTO        3'h0
`define HFCB_TAG_BLK4        3'h1
`define HFCB_TAG_BLK8        3'h2
`define HFCB_TAG_BLK32       3'h3

`define HFCB_MAX_USER_BYTES  8'h40
`define HFCB_HEAD_DEFAULT    8'h44
`define HFCB_HEADS           8

`define HFCB_RING_DEPTH      2048
`define HFCB_RING_BYTES      16384
`define HFCB_REC_BYTES_PLAIN 4'hA
`define HFCB_REC_BYTES_GROUP 4'hC
`define HFCB_MAX_RECS_PLAIN  12'h666
`define HFCB_MAX_RECS_GROUP  12'h555

`define HFCB_CLK_KHZ         50000
`define HFCB_BYPASS_MS       48
`define HFCB_WAIT_INV_MS     15
`define HFCB_WAIT_RD_MS      25
`define HFCB_WAIT_WR_MS      35

`endif

// ---- rtl/hfcb_fifo.v ----
// small record FIFO between the head bus and the ring store
`timescale 1ns/1ps
module hfcb_fifo #(
	parameter WIDTH = 72,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             clk,
	input  wire             arst_n,
	input  wire             ce,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	reg             ready_reg;
	reg             empty_reg;
	wire            push;
	wire            pop;
	wire [AW:0]     count_next;

	assign in_ready   = ready_reg;
	assign out_valid  = ~empty_reg;
	assign out_data   = mem[rd_ptr_reg];
	assign push       = in_valid & ready_reg;
	assign pop        = out_ready & ~empty_reg;
	assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always @(posedge clk) begin
		if (ce && push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
			ready_reg  <= 1'b1;
			empty_reg  <= 1'b1;
		end else if (ce) begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_next;
			ready_reg <= (count_next != DEPTH);
			empty_reg <= (count_next == {(AW+1){1'b0}});
		end
	end
endmodule

// ---- rtl/hfcb_slot_timer.v ----
// pass timer: bypass slot followed by wait slot, repeating while run is high
`timescale 1ns/1ps
module hfcb_slot_timer (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        ce,
	input  wire        run,
	input  wire [21:0] bypass_cyc,
	input  wire [21:0] wait_cyc,
	output reg         pass_start,
	output reg         in_bypass
);
	reg [21:0] cnt_reg;
	reg        armed_reg;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg    <= 22'h000000;
			armed_reg  <= 1'b1;
			pass_start <= 1'b0;
			in_bypass  <= 1'b0;
		end else if (ce) begin
			pass_start <= 1'b0;
			if (!run) begin
				cnt_reg   <= 22'h000000;
				armed_reg <= 1'b1;
				in_bypass <= 1'b0;
			end else if (armed_reg) begin
				armed_reg  <= 1'b0;
				pass_start <= 1'b1;
				in_bypass  <= 1'b1;
				cnt_reg    <= 22'h000000;
			end else if (in_bypass && cnt_reg == bypass_cyc - 22'h000001) begin
				in_bypass <= 1'b0;
				cnt_reg   <= 22'h000000;
			end else if (!in_bypass && cnt_reg == wait_cyc - 22'h000001) begin
				in_bypass  <= 1'b1;
				pass_start <= 1'b1;
				cnt_reg    <= 22'h000000;
			end else begin
				cnt_reg <= cnt_reg + 22'h000001;
			end
		end
	end
endmodule

// ---- tb/hfcb_head_model.sv ----
// head bus model: answers each poll with one tag record while a tag is present and no earlier record is still pending
`timescale 1ns/1ps
module hfcb_head_model (
	input  logic        clk,
	input  logic        arst_n,
	input  logic        has_tag,
	input  logic [63:0] tag_uid,
	input  logic        head_poll,
	input  logic [7:0]  head_poll_addr,
	output logic        head_rec_valid,
	input  logic        head_rec_ready,
	output logic [63:0] head_rec_uid,
	output logic [7:0]  head_rec_addr
);
	logic [63:0] uid_reg;
	logic [7:0]  addr_reg;
	// idle lines show the inverse so stale data never looks valid
	assign head_rec_uid  = head_rec_valid ? uid_reg : ~uid_reg;
	assign head_rec_addr = head_rec_valid ? addr_reg : ~addr_reg;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			head_rec_valid <= 1'b0;
			uid_reg        <= 64'h0;
			addr_reg       <= 8'h00;
		end else if (head_rec_valid && head_rec_ready) begin
			head_rec_valid <= 1'b0;
		end else if (head_poll && has_tag && !head_rec_valid) begin
			head_rec_valid <= 1'b1;
			uid_reg        <= tag_uid;
			addr_reg       <= head_poll_addr;
		end
	end
endmodule

// ---- tb/hfcb_ctrl_assertions.sv ----
// checker of command answers, polling and head addressing
`timescale 1ns/1ps
module hfcb_ctrl_chk (
	input logic        clk,
	input logic        arst_n,
	input logic        ce,
	input logic        cmd_strobe,
	input logic [15:0] cmd_code,
	input logic [2:0]  tag_type,
	input logic [2:0]  continuous_cmd_select,
	input logic [7:0]  continuous_length,
	input logic        cmd_busy,
	input logic [15:0] resp_code,
	input logic        resp_error,
	input logic [15:0] fifo_bytes_waiting,
	input logic        fifo_full_err,
	input logic        cont_running,
	input logic        buf_byte_valid,
	input logic        head_preload,
	input logic        head_poll,
	input logic [7:0]  head_poll_addr,
	input logic        head_attach,
	input logic [7:0]  head_attach_addr,
	input logic        addr_assign_valid,
	input logic [7:0]  addr_assign
);
	logic go;
	logic rw;
	logic [3:0] since_poll;
	assign go = ce && cmd_strobe && !cmd_busy;
	assign rw = continuous_cmd_select == 3'h1 || continuous_cmd_select == 3'h3;
	// a stop drops the count, since a restart may poll at once
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			since_poll <= 4'hF;
		end else if (ce && head_poll) begin
			since_poll <= 4'h0;
		end else if (ce && !cont_running) begin
			since_poll <= 4'hF;
		end else if (ce && since_poll != 4'hF) begin
			since_poll <= since_poll + 4'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_cont_start_echo: assert property (go && cmd_code == 16'h0010 && continuous_cmd_select == 3'h0
		&& tag_type < 3'h4 |=> resp_code == 16'h0010 && !resp_error && cont_running && head_preload)
		else $error("continuous start not echoed");
	a_select_reject: assert property (go && cmd_code == 16'h0010 && continuous_cmd_select > 3'h3
		|=> resp_error && !head_preload) else $error("bad operation accepted");
	a_length_cap: assert property (go && cmd_code == 16'h0010 && rw && continuous_length > 8'h40
		|=> resp_error) else $error("length above cap accepted");
	a_auto_tag_rw: assert property (go && cmd_code == 16'h0010 && rw && tag_type == 3'h0
		|=> resp_error) else $error("read or write without tag type accepted");
	a_idle_keeps_run: assert property (go && cmd_code == 16'h0000
		|=> $stable(cont_running) && resp_code == 16'h0000) else $error("idle changed mode");
	a_stop_ends: assert property (go && cmd_code == 16'h0012
		|=> !cont_running && resp_code == 16'h0012) else $error("stop did not end mode");
	a_reset_empties: assert property (go && cmd_code == 16'h0800
		|=> !cont_running && !fifo_full_err ##1 fifo_bytes_waiting == 16'h0000) else $error("reset kept data");
	a_read_starts: assert property (go && cmd_code == 16'h0011
		|=> cmd_busy && resp_code == 16'h0000) else $error("read buffer start wrong");
	a_bytes_in_read: assert property (buf_byte_valid |-> cmd_busy) else $error("byte outside read");
	a_preload_pulse: assert property (head_preload |=> !head_preload) else $error("preload not a pulse");
	a_poll_spacing: assert property (ce && head_poll |-> since_poll >= 4'h8) else $error("polls too close");
	a_poll_address: assert property (head_poll |-> head_poll_addr >= 8'h01
		&& head_poll_addr <= 8'h08) else $error("poll address out of range");
	a_assign_cause: assert property (addr_assign_valid |-> $past(head_attach)
		&& $past(head_attach_addr) == 8'h44 && addr_assign != 8'h00 && addr_assign <= 8'h08)
		else $error("address given without default head");
endmodule
bind hfcb_ctrl hfcb_ctrl_chk hfcb_ctrl_chk_inst (.clk, .arst_n, .ce, .cmd_strobe, .cmd_code, .tag_type,
	.continuous_cmd_select, .continuous_length, .cmd_busy, .resp_code, .resp_error, .fifo_bytes_waiting,
	.fifo_full_err, .cont_running, .buf_byte_valid, .head_preload, .head_poll, .head_poll_addr,
	.head_attach, .head_attach_addr, .addr_assign_valid, .addr_assign);

// ---- tb/hfcb_ctrl_tb.sv ----
// testbench of the continuous bus mode command handler
`timescale 1ns/1ps
module hfcb_ctrl_tb;
	localparam logic [63:0] UID = 64'h8877665544332211;
	logic        clk = 0, arst_n = 0, ce = 1, cmd_strobe = 0, grouping_en = 0, head_attach = 0;
	logic        head_detach = 0, has_tag = 0;
	logic [15:0] cmd_code = 0, continuous_start_addr = 0, buf_read_len = 0;
	logic [2:0]  tag_type = 0, continuous_cmd_select = 0;
	logic [7:0]  continuous_length = 0, head_attach_addr = 0, head_detach_addr = 0;
	wire         cmd_busy, resp_error, fifo_full_err, cont_running, buf_byte_valid, head_preload;
	wire         head_poll, head_rec_valid, head_rec_ready, addr_assign_valid;
	wire [15:0]  resp_code, fifo_bytes_waiting, preload_addr;
	wire [7:0]   buf_byte, head_preload_mask, preload_len, head_poll_addr, head_rec_addr, addr_assign;
	wire [2:0]   preload_op, preload_tag;
	wire [63:0]  head_rec_uid;
	int          mismatches = 0, compares = 0, cyc = 0, hs = 0;
	logic [7:0]  got[$];
	// short pass times keep the run small
	hfcb_ctrl #(.BYPASS_CYC(20), .WAIT_INV_CYC(5), .WAIT_RD_CYC(8), .WAIT_WR_CYC(11)) hfcb_ctrl_inst (
		.clk, .arst_n, .ce, .cmd_strobe, .cmd_code, .tag_type, .continuous_cmd_select, .continuous_length,
		.continuous_start_addr, .grouping_en, .buf_read_len, .cmd_busy, .resp_code, .resp_error,
		.fifo_bytes_waiting, .fifo_full_err, .cont_running, .buf_byte, .buf_byte_valid, .head_preload,
		.head_preload_mask, .preload_op, .preload_tag, .preload_len, .preload_addr, .head_poll,
		.head_poll_addr, .head_rec_valid, .head_rec_ready, .head_rec_uid, .head_rec_addr, .head_attach,
		.head_attach_addr, .head_detach, .head_detach_addr, .addr_assign_valid, .addr_assign);
	hfcb_head_model hfcb_head_model_inst (.clk, .arst_n, .has_tag, .tag_uid(UID), .head_poll,
		.head_poll_addr, .head_rec_valid, .head_rec_ready, .head_rec_uid, .head_rec_addr);
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		if (head_rec_valid && head_rec_ready) hs++;
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			$display("Error at %0t: run did not finish", $time);
			wrap_up;
		end
	end
	task automatic chk(input logic [15:0] g, e, input string m);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task automatic cmd(input logic [15:0] c);
		@(posedge clk);
		cmd_strobe <= 1;
		cmd_code <= c;
		@(posedge clk);
		cmd_strobe <= 0;
		#1;
	endtask
	task automatic cont(input logic [2:0] s, t, input logic [7:0] l, input logic [15:0] a, input logic e);
		@(posedge clk);
		continuous_cmd_select <= s;
		tag_type <= t;
		continuous_length <= l;
		continuous_start_addr <= a;
		cmd(16'h0010);
		chk(resp_error, e, "param check");
		chk(head_preload, !e, "preload");
	endtask
	task automatic rd(input logic [15:0] len, input int want);
		int k;
		got.delete();
		@(posedge clk);
		buf_read_len <= len;
		cmd(16'h0011);
		for (k = 0; k < 2000 && cmd_busy; k++) begin
			@(posedge clk);
			#1;
			if (buf_byte_valid === 1'b1) got.push_back(buf_byte);
		end
		chk(got.size(), want, "byte count");
		chk(resp_code, 16'h0011, "read echo");
		for (k = 0; k + 9 < got.size(); k += 10) begin
			for (int j = 0; j < 8; j++) chk(got[k+j], UID[8*j+:8], "uid byte");
			chk(got[k+8], 8'h00, "reserved");
			chk(got[k+9] >= 1 && got[k+9] <= 3, 1, "head address");
		end
	endtask
	task automatic attach(input logic [7:0] a, input logic v, input logic [7:0] e);
		@(posedge clk);
		head_attach <= 1;
		head_attach_addr <= a;
		@(posedge clk);
		head_attach <= 0;
		#1;
		chk(addr_assign_valid, v, "assign flag");
		if (v) chk(addr_assign, e, "assigned address");
	endtask
	task automatic t_attach;
		for (int i = 1; i <= 3; i++) attach(8'h44, 1, i);
		attach(8'h05, 0, 0);
		@(posedge clk);
		ce <= 0;
		attach(8'h44, 0, 0);
		@(posedge clk);
		ce <= 1;
		@(posedge clk);
		head_detach <= 1;
		head_detach_addr <= 8'h02;
		@(posedge clk);
		head_detach <= 0;
		attach(8'h44, 1, 2);
		$display("test attach done");
	endtask
	task automatic t_params;
		logic [2:0] bs[5] = '{4, 1, 1, 3, 1};
		logic [2:0] bt[5] = '{1, 0, 1, 2, 3};
		logic [7:0] bl[5] = '{8, 8, 68, 12, 32};
		logic [7:0] ba[5] = '{0, 0, 0, 0, 16};
		for (int i = 0; i < 5; i++) cont(bs[i], bt[i], bl[i], ba[i], 1);
		chk(cont_running, 0, "mode after refusal");
		for (int s = 0; s < 4; s++) begin
			cont(s, 3, 8'h20, 16'h0020, 0);
			chk(preload_op, s, "preload op");
			chk(preload_len, 8'h20, "preload length");
			chk(preload_addr, 16'h0020, "preload start");
			chk(preload_tag, 3, "preload tag");
			chk(head_preload_mask, 8'h07, "preload heads");
			cmd(16'h0012);
			chk(cont_running, 0, "stopped");
		end
		cmd(16'h0123);
		chk(resp_error, 1, "unknown code");
		$display("test parameters done");
	endtask
	task automatic t_collect;
		int c0;
		hs = 0;
		cont(0, 0, 0, 0, 0);
		cmd(16'h0000);
		chk(cont_running, 1, "idle keeps mode");
		chk(resp_code, 16'h0000, "idle echo");
		@(posedge head_poll);
		c0 = cyc;
		@(posedge head_poll);
		chk(cyc - c0, 25, "inventory pass length");
		has_tag <= 1;
		for (int k = 0; k < 400 && fifo_bytes_waiting < 30; k++) @(posedge clk);
		has_tag <= 0;
		repeat (80) @(posedge clk);
		chk(fifo_bytes_waiting, hs * 10, "bytes waiting");
		rd(16'd15, 10);
		chk(fifo_bytes_waiting, hs * 10 - 10, "rest kept");
		cmd(16'h0800);
		@(posedge clk);
		#1;
		chk(fifo_bytes_waiting, 0, "reset empties");
		$display("test collect done");
	endtask
	task automatic t_group;
		@(posedge clk);
		grouping_en <= 1;
		cont(0, 0, 0, 0, 0);
		hs = 0;
		has_tag <= 1;
		for (int k = 0; k < 400 && hs < 3; k++) @(posedge clk);
		has_tag <= 0;
		repeat (80) @(posedge clk);
		chk(fifo_bytes_waiting, 16'd12, "one grouped record");
		rd(16'd12, 12);
		chk(got[10], hs, "read count low");
		chk(got[11], 0, "read count high");
		cmd(16'h0012);
		$display("test grouping done");
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1;
		t_attach;
		t_params;
		t_collect;
		t_group;
		wrap_up;
	end
endmodule
